//--- ppc_checker.sv
// Port-level assertions for the programming panel command logic.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.vh"
module ppc_checker (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        key_valid,
	input wire logic [3:0]  key_code,
	input wire logic [3:0]  key_digit,
	input wire logic        write_lock,
	input wire logic        cursor_relay,
	input wire logic        cursor_col_bottom,
	input wire logic        cursor_top_right_single,
	input wire logic        assembly_complete,
	input wire logic [3:0]  mem_cmd,
	input wire logic        display_update,
	input wire logic        screen_clear,
	input wire logic        confirm_prompt,
	input wire logic        menu_active,
	input wire logic        sweep_run,
	input wire logic        outputs_enable,
	input wire logic        key_refused,
	input wire logic [59:0] watch_value
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic digit;
	logic plain;
	logic confirm_key;
	logic shifted;
	assign digit = key_valid && key_code == `PPC_KEY_DIGIT;
	assign plain = key_valid && !menu_active && !write_lock;
	assign confirm_key = digit && key_digit == `PPC_OPT_CONFIRM;
	// Shift only lives until the next key, so it is tracked here rather than trusted from outside.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) shifted <= 1'b0;
		else if (key_valid && !menu_active) shifted <= key_code == `PPC_KEY_SHIFT && !shifted;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	reset_state_a: assert property ($fell(rst) |-> !menu_active && !confirm_prompt) else $error("menu not idle after reset");
	menu_enter_a: assert property (key_valid && key_code == `PPC_KEY_SUPERVISOR && !menu_active |=> screen_clear && menu_active) else $error("menu entry wrong");
	lock_refuse_a: assert property (key_valid && write_lock && !menu_active && key_code inside {`PPC_KEY_START_NEXT, `PPC_KEY_DELETE, `PPC_KEY_DISABLE, `PPC_KEY_FORCE} |=> key_refused && mem_cmd == `PPC_CMD_NONE) else $error("locked key acted");
	insert_cmd_a: assert property (plain && key_code == `PPC_KEY_START_NEXT |=> mem_cmd == `PPC_CMD_INSERT_NET) else $error("insert missing");
	confirm_ask_a: assert property (digit && menu_active && !confirm_prompt && !write_lock && (key_digit == `PPC_OPT_STOP || (key_digit == `PPC_OPT_CLEAR && !sweep_run)) |=> confirm_prompt) else $error("no confirm prompt");
	cancel_a: assert property (digit && confirm_prompt && key_digit <= `PPC_OPT_VERIFY |=> !confirm_prompt && $stable(sweep_run) && mem_cmd == `PPC_CMD_NONE) else $error("cancel executed");
	stop_cause_a: assert property ($fell(sweep_run) |-> $past(confirm_key)) else $error("sweep stopped without confirm");
	outputs_off_a: assert property (!sweep_run [*3] |-> !outputs_enable) else $error("outputs on while stopped");
	clear_refuse_a: assert property (digit && menu_active && !confirm_prompt && sweep_run && key_digit inside {`PPC_OPT_CLEAR, `PPC_OPT_LOAD} |=> key_refused && mem_cmd == `PPC_CMD_NONE) else $error("clear or load while running");
	relay_keep_a: assert property (plain && !shifted && key_code == `PPC_KEY_DELETE && cursor_relay && !cursor_col_bottom && !cursor_top_right_single |=> mem_cmd == `PPC_CMD_NONE) else $error("inner relay deleted");
	net_delete_a: assert property (plain && shifted && key_code == `PPC_KEY_DELETE |=> mem_cmd == `PPC_CMD_DELETE_NET && display_update) else $error("network delete wrong");
	partial_enter_a: assert property (key_valid && !menu_active && key_code == `PPC_KEY_ENTER && !assembly_complete |=> key_refused && mem_cmd == `PPC_CMD_NONE) else $error("partial element entered");
	value_clamp_a: assert property (watch_value[9:0] <= `PPC_REG_MAX) else $error("watched value above range");
endmodule
bind ppc_command_logic ppc_checker i_ppc_checker (.clock, .rst, .key_valid, .key_code, .key_digit, .write_lock,
	.cursor_relay, .cursor_col_bottom, .cursor_top_right_single, .assembly_complete, .mem_cmd, .display_update,
	.screen_clear, .confirm_prompt, .menu_active, .sweep_run, .outputs_enable, .key_refused, .watch_value);
`default_nettype wire

//--- ppc_command_logic.v
// Keypad command interpreter for the controller programming panel.
// Overview of operation
// - With write lock on, protected network keys and supervisory options are ignored.
// - Insert-network adds a network after the shown one, renumbering those following.
// - Insert with nothing shown places the new network first, renumbering all.
// - Supervisory key clears screen; digits 0-6 pick exit, stop, start, clear, load, dump, verify.
// - While sweep is stopped, all outputs are held off until start.
// - Clear removes all stored logic from program memory.
// - Dump sends all memory out the tape port at 600 baud.
// - Scanning keeps running during a dump.
// - Clear and load are refused unless the sweep was stopped first.
// - After a good load, scanning stays stopped until start or power cycle.
// - Verify compares memory against the record received from the tape port.
// - Stop and clear prompt for confirm and execute only on digit 7 next.
// - Any digit 0-6 during a confirm prompt cancels the pending operation.
// - Relay elements delete only at column bottom, or top rung right with one left.
// - Deleting a function from its top element removes all its numeric elements.
// - Shift then delete removes the network under cursor, renumbering those following.
// - Each deletion updates display and program memory in one operation.
// - Disabling a coil or input freezes its state and survives power loss.
// - Disable again on a disabled reference restores normal control.
// - Force acts only on disabled references, toggling their state each press.
// - Status area shows six references: discretes ON/OFF, registers 000 to 999.
// - An element is refused until every part of it has been specified.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.vh"
module ppc_command_logic #(
	parameter MEM_WORDS  = 256,
	parameter REFS       = 256,
	parameter BIT_CYCLES = `PPC_BIT_CYCLES
) (
	input  wire        clock,
	input  wire        rst,
	input  wire        key_valid,
	input  wire [3:0]  key_code,
	input  wire [3:0]  key_digit,
	input  wire        write_lock,
	input  wire [7:0]  shown_step,
	input  wire        screen_empty,
	input  wire        cursor_relay,
	input  wire        cursor_col_bottom,
	input  wire        cursor_top_right_single,
	input  wire        cursor_fn_top,
	input  wire        cursor_is_ref,
	input  wire [7:0]  cursor_ref,
	input  wire        assembly_complete,
	input  wire        ref_state_in,
	input  wire [7:0]  ref_index_in,
	input  wire [9:0]  reg_value_in,
	input  wire [7:0]  watch_sel_0,
	input  wire [7:0]  watch_sel_1,
	input  wire [7:0]  watch_sel_2,
	input  wire [7:0]  watch_sel_3,
	input  wire [7:0]  watch_sel_4,
	input  wire [7:0]  watch_sel_5,
	input  wire [5:0]  watch_is_reg,
	input  wire [7:0]  mem_rdata,
	input  wire        tape_rx,
	output reg         tape_tx,
	output reg  [3:0]  mem_cmd,
	output reg  [7:0]  mem_cmd_step,
	output reg         display_update,
	output reg         screen_clear,
	output reg         confirm_prompt,
	output reg         menu_active,
	output reg         sweep_run,
	output reg         outputs_enable,
	output reg  [7:0]  mem_addr,
	output reg  [7:0]  mem_wdata,
	output reg         mem_we,
	output reg         verify_done,
	output reg         verify_error,
	output reg         key_refused,
	output reg  [5:0]  watch_on,
	output reg  [59:0] watch_value,
	output reg         ref_override,
	output reg         ref_forced_state
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [5:0] ST_NORMAL  = 6'h01;
	localparam [5:0] ST_MENU    = 6'h02;
	localparam [5:0] ST_CONFIRM = 6'h04;
	localparam [5:0] ST_DUMP    = 6'h08;
	localparam [5:0] ST_LOAD    = 6'h10;
	localparam [5:0] ST_VERIFY  = 6'h20;

	reg  [5:0] state;
	reg  [5:0] next_state;
	reg  [3:0] pending_opt;
	reg        shift_held;
	reg        stopped_by_menu;
	reg  [7:0] xfer_addr;
	reg        xfer_wait;
	reg        load_ok;
	reg  [REFS-1:0] disabled;
	reg  [REFS-1:0] frozen;
	wire       tx_busy;
	wire       tx_line;
	wire       rx_valid;
	wire [7:0] rx_byte;
	wire       key_digit_now;
	wire       opt_protected;
	wire [7:0] last_addr;
	wire [31:0] last_word;

	assign key_digit_now = key_valid && key_code == `PPC_KEY_DIGIT;
	assign opt_protected = key_digit == `PPC_OPT_STOP || key_digit == `PPC_OPT_START ||
		key_digit == `PPC_OPT_CLEAR || key_digit == `PPC_OPT_DUMP;
	assign last_word     = MEM_WORDS - 1;
	assign last_addr     = last_word[7:0];

	ppc_tape_port #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_tape (
		.clock   (clock),
		.rst     (rst),
		.tx_go   (state == ST_DUMP && !tx_busy && !xfer_wait),
		.tx_byte (mem_rdata),
		.tx_busy (tx_busy),
		.tx_line (tx_line),
		.rx_line (tape_rx),
		.rx_valid(rx_valid),
		.rx_byte (rx_byte)
	);

	// ----------------------------------------
	// Supervisory menu sequencing
	// ----------------------------------------
	always @* begin
		next_state = state;
		case (state)
			ST_NORMAL: begin
				if (key_valid && key_code == `PPC_KEY_SUPERVISOR)
					next_state = ST_MENU;
			end
			ST_MENU: begin
				if (key_digit_now && !(write_lock && opt_protected)) begin
					case (key_digit)
						`PPC_OPT_EXIT:   next_state = ST_NORMAL;
						`PPC_OPT_STOP:   next_state = ST_CONFIRM;
						`PPC_OPT_CLEAR:  next_state = stopped_by_menu ? ST_CONFIRM : ST_MENU;
						`PPC_OPT_LOAD:   next_state = stopped_by_menu ? ST_LOAD : ST_MENU;
						`PPC_OPT_DUMP:   next_state = ST_DUMP;
						`PPC_OPT_VERIFY: next_state = ST_VERIFY;
						default:         next_state = ST_MENU;
					endcase
				end
			end
			ST_CONFIRM: begin
				if (key_digit_now && key_digit <= `PPC_OPT_CONFIRM)
					next_state = ST_MENU;
			end
			ST_DUMP, ST_VERIFY: begin
				if (xfer_addr == last_addr && !xfer_wait && !tx_busy && (state == ST_VERIFY ? rx_valid : 1'b1))
					next_state = ST_MENU;
			end
			ST_LOAD: begin
				if (rx_valid && xfer_addr == last_addr)
					next_state = ST_MENU;
			end
			default: next_state = ST_NORMAL;
		endcase
	end

	// ----------------------------------------
	// Command execution
	// ----------------------------------------
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			state           <= ST_NORMAL;
			pending_opt     <= 4'h0;
			shift_held      <= 1'b0;
			stopped_by_menu <= 1'b0;
			xfer_addr       <= 8'h00;
			xfer_wait       <= 1'b0;
			load_ok         <= 1'b1;
			tape_tx         <= 1'b1;
			mem_cmd         <= `PPC_CMD_NONE;
			mem_cmd_step    <= 8'h00;
			display_update  <= 1'b0;
			screen_clear    <= 1'b0;
			confirm_prompt  <= 1'b0;
			menu_active     <= 1'b0;
			sweep_run       <= 1'b1;
			outputs_enable  <= 1'b1;
			mem_addr        <= 8'h00;
			mem_wdata       <= 8'h00;
			mem_we          <= 1'b0;
			verify_done     <= 1'b0;
			verify_error    <= 1'b0;
			key_refused     <= 1'b0;
			ref_override    <= 1'b0;
			ref_forced_state <= 1'b0;
		end else begin
			state          <= next_state;
			tape_tx        <= tx_line;
			mem_cmd        <= `PPC_CMD_NONE;
			display_update <= 1'b0;
			screen_clear   <= 1'b0;
			mem_we         <= 1'b0;
			verify_done    <= 1'b0;
			key_refused    <= 1'b0;
			menu_active    <= next_state != ST_NORMAL;
			confirm_prompt <= next_state == ST_CONFIRM;
			outputs_enable <= sweep_run && !stopped_by_menu;
			ref_override   <= disabled[ref_index_in];
			ref_forced_state <= frozen[ref_index_in];
			if (key_valid && key_code == `PPC_KEY_SHIFT)
				shift_held <= !shift_held;
			else if (key_valid && key_code != `PPC_KEY_SUPERVISOR)
				shift_held <= 1'b0;
			case (state)
				ST_NORMAL: begin
					if (key_valid) begin
						case (key_code)
							`PPC_KEY_SUPERVISOR: screen_clear <= 1'b1;
							`PPC_KEY_START_NEXT: begin
								if (write_lock) begin
									key_refused <= 1'b1;
								end else begin
									mem_cmd        <= `PPC_CMD_INSERT_NET;
									mem_cmd_step   <= screen_empty ? 8'h01 : shown_step + 8'h01;
									display_update <= 1'b1;
								end
							end
							`PPC_KEY_DELETE: begin
								if (write_lock) begin
									key_refused <= 1'b1;
								end else if (shift_held) begin
									mem_cmd        <= `PPC_CMD_DELETE_NET;
									mem_cmd_step   <= shown_step;
									display_update <= 1'b1;
								end else if (!cursor_relay && cursor_fn_top) begin
									mem_cmd        <= `PPC_CMD_DELETE_FN;
									mem_cmd_step   <= shown_step;
									display_update <= 1'b1;
								end else if (cursor_relay && (cursor_col_bottom || cursor_top_right_single)) begin
									mem_cmd        <= `PPC_CMD_DELETE_EL;
									mem_cmd_step   <= shown_step;
									display_update <= 1'b1;
								end else begin
									key_refused <= 1'b1;
								end
							end
							`PPC_KEY_ENTER: begin
								if (assembly_complete) begin
									mem_cmd        <= `PPC_CMD_ENTER_EL;
									mem_cmd_step   <= shown_step;
									display_update <= 1'b1;
								end else begin
									key_refused <= 1'b1;
								end
							end
							`PPC_KEY_DISABLE, `PPC_KEY_FORCE: begin
								if (write_lock || !cursor_is_ref)
									key_refused <= 1'b1;
								else if (key_code == `PPC_KEY_FORCE && !disabled[cursor_ref])
									key_refused <= 1'b1;
							end
							default: ;
						endcase
					end
				end
				ST_MENU: begin
					if (key_digit_now) begin
						if (write_lock && opt_protected) begin
							key_refused <= 1'b1;
						end else begin
							pending_opt <= key_digit;
							if (key_digit == `PPC_OPT_START) begin
								sweep_run       <= 1'b1;
								stopped_by_menu <= 1'b0;
							end
							if ((key_digit == `PPC_OPT_CLEAR || key_digit == `PPC_OPT_LOAD) && !stopped_by_menu)
								key_refused <= 1'b1;
							xfer_addr <= 8'h00;
							mem_addr  <= 8'h00;
							xfer_wait <= 1'b1;
							load_ok   <= 1'b1;
							verify_error <= 1'b0;
						end
					end
				end
				ST_CONFIRM: begin
					if (key_digit_now && key_digit == `PPC_OPT_CONFIRM) begin
						if (pending_opt == `PPC_OPT_STOP) begin
							sweep_run       <= 1'b0;
							stopped_by_menu <= 1'b1;
						end else begin
							mem_cmd <= `PPC_CMD_CLEAR_ALL;
						end
					end
				end
				ST_DUMP: begin
					// Sweep is left alone here; the dump only reads memory.
					xfer_wait <= 1'b0;
					if (!tx_busy && !xfer_wait) begin
						xfer_addr <= xfer_addr + 8'h01;
						mem_addr  <= xfer_addr + 8'h01;
						xfer_wait <= 1'b1;
					end
				end
				ST_LOAD: begin
					if (rx_valid) begin
						mem_addr  <= xfer_addr;
						mem_wdata <= rx_byte;
						mem_we    <= 1'b1;
						xfer_addr <= xfer_addr + 8'h01;
						if (xfer_addr == last_addr)
							sweep_run <= 1'b0;
					end
				end
				ST_VERIFY: begin
					xfer_wait <= 1'b0;
					if (rx_valid) begin
						if (rx_byte != mem_rdata)
							verify_error <= 1'b1;
						verify_done <= xfer_addr == last_addr;
						xfer_addr   <= xfer_addr + 8'h01;
						mem_addr    <= xfer_addr + 8'h01;
					end
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Disable and force bits
	// ----------------------------------------
	// These flops keep no reset so that a disable outlives a power loss.
	initial begin
		disabled = {REFS{1'b0}};
		frozen   = {REFS{1'b0}};
	end
	always @(posedge clock) begin
		if (state == ST_NORMAL && key_valid && !write_lock && cursor_is_ref) begin
			if (key_code == `PPC_KEY_DISABLE) begin
				disabled[cursor_ref] <= !disabled[cursor_ref];
				frozen[cursor_ref]   <= ref_state_in;
			end else if (key_code == `PPC_KEY_FORCE && disabled[cursor_ref]) begin
				frozen[cursor_ref] <= !frozen[cursor_ref];
			end
		end
	end

	// ----------------------------------------
	// Status area
	// ----------------------------------------
	genvar w;
	generate
		for (w = 0; w < 6; w = w + 1) begin : g_watch
			wire [7:0] sel = w == 0 ? watch_sel_0 : w == 1 ? watch_sel_1 : w == 2 ? watch_sel_2 :
				w == 3 ? watch_sel_3 : w == 4 ? watch_sel_4 : watch_sel_5;
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					watch_on[w]            <= 1'b0;
					watch_value[w*10 +: 10] <= 10'h000;
				end else if (ref_index_in == sel) begin
					watch_on[w] <= disabled[sel] ? frozen[sel] : ref_state_in;
					if (watch_is_reg[w])
						watch_value[w*10 +: 10] <= reg_value_in > `PPC_REG_MAX ? `PPC_REG_MAX : reg_value_in;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

//--- ppc_command_logic_bench.sv
// Self-checking testbench for the programming panel command logic.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.vh"
module ppc_command_logic_bench;
	logic        clock, rst, key_valid, write_lock, screen_empty, cursor_relay, cursor_col_bottom;
	logic        cursor_top_right_single, cursor_fn_top, cursor_is_ref, assembly_complete, ref_state_in;
	logic [3:0]  key_code, key_digit, mem_cmd;
	logic [7:0]  shown_step, cursor_ref, ref_index_in, watch_sel_0, watch_sel_1, mem_rdata, mem_addr, mem_wdata, b;
	logic [7:0]  watch_sel_2, mem_cmd_step;
	logic [9:0]  reg_value_in;
	logic [5:0]  watch_is_reg, watch_on;
	logic [59:0] watch_value;
	logic        tape_rx, tape_tx, display_update, screen_clear, confirm_prompt, menu_active, sweep_run;
	logic        outputs_enable, mem_we, key_refused, ref_override, ref_forced_state;
	logic [3:0]  locked [4] = '{`PPC_KEY_START_NEXT, `PPC_KEY_DELETE, `PPC_KEY_DISABLE, `PPC_KEY_FORCE};
	int          miscompares, tests_run, cycles;
	// A short bit time keeps the tape frames inside the run; all expectations follow from 8.
	ppc_command_logic #(.MEM_WORDS(16), .BIT_CYCLES(8)) i_ppc_command_logic (.clock, .rst, .key_valid, .key_code,
		.key_digit, .write_lock, .shown_step, .screen_empty, .cursor_relay, .cursor_col_bottom,
		.cursor_top_right_single, .cursor_fn_top, .cursor_is_ref, .cursor_ref, .assembly_complete, .ref_state_in,
		.ref_index_in, .reg_value_in, .watch_sel_0, .watch_sel_1, .watch_sel_2, .watch_sel_3(8'h03),
		.watch_sel_4(8'h04), .watch_sel_5(8'h05), .watch_is_reg, .mem_rdata, .tape_rx, .tape_tx, .mem_cmd,
		.mem_cmd_step, .display_update, .screen_clear, .confirm_prompt, .menu_active, .sweep_run, .outputs_enable,
		.mem_addr, .mem_wdata, .mem_we, .verify_done(), .verify_error(), .key_refused, .watch_on, .watch_value,
		.ref_override, .ref_forced_state);
	ppc_partner i_ppc_partner (.clock, .mem_addr, .mem_wdata, .mem_we, .mem_cmd, .mem_rdata, .tape_rx);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic key(input logic [3:0] c, input logic [3:0] d);
		@(posedge clock);
		key_valid <= 1'b1;
		key_code <= c;
		key_digit <= d;
		@(posedge clock);
		key_valid <= 1'b0;
		#1;
	endtask
	task automatic opt(input logic [3:0] d);
		if (menu_active !== 1'b1) key(`PPC_KEY_SUPERVISOR, 4'h0);
		key(`PPC_KEY_DIGIT, d);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic rx(output logic [7:0] v);
		int n;
		n = 0;
		while (tape_tx !== 1'b0 && n < 400) begin
			@(posedge clock);
			n++;
		end
		repeat (4) @(posedge clock);
		chk(tape_tx, 1'b0);
		for (int i = 0; i < 8; i++) begin
			repeat (8) @(posedge clock);
			v[i] = tape_tx;
		end
		repeat (8) @(posedge clock);
		chk(tape_tx, 1'b1);
	endtask
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 8000) begin
			miscompares++;
			conclude;
		end
	end
	initial begin
		rst = 1'b1;
		{key_valid, key_code, key_digit, shown_step, cursor_ref, reg_value_in} = '0;
		{write_lock, screen_empty, cursor_relay, cursor_col_bottom, cursor_top_right_single} = 5'h00;
		{cursor_fn_top, cursor_is_ref, assembly_complete, ref_state_in} = 4'h1;
		{ref_index_in, watch_sel_0, watch_sel_1, watch_sel_2, watch_is_reg} = {8'h30, 8'h30, 8'h21, 8'h02, 6'h01};
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		#1;
		chk({sweep_run, outputs_enable, tape_tx, menu_active, confirm_prompt}, 5'h1C);
		$display("reset test done");
		@(posedge clock) reg_value_in <= 10'h3FF;
		repeat (7) @(posedge clock) ref_index_in <= ref_index_in ^ 8'h11;
		settle(4);
		chk(watch_value[9:0], 10'd999);
		chk(watch_on[1], 1'b1);
		$display("status area test done");
		opt(`PPC_OPT_DUMP);
		chk(sweep_run, 1'b1);
		for (int a = 0; a < 16; a++) begin
			rx(b);
			chk(b, 8'(a) ^ 8'hA5);
		end
		chk(sweep_run, 1'b1);
		key(`PPC_KEY_DIGIT, `PPC_OPT_EXIT);
		chk(menu_active, 1'b0);
		$display("dump test done");
		@(posedge clock) write_lock <= 1'b1;
		foreach (locked[i]) begin
			key(locked[i], 4'h0);
			chk({key_refused, mem_cmd}, {1'b1, `PPC_CMD_NONE});
		end
		foreach (locked[i]) begin
			opt(4'(i == 0 ? 1 : i + 1 + (i == 3)));
			chk({key_refused, confirm_prompt}, 2'b10);
		end
		@(posedge clock) write_lock <= 1'b0;
		key(`PPC_KEY_DIGIT, `PPC_OPT_EXIT);
		$display("lock test done");
		@(posedge clock) shown_step <= 8'h05;
		key(`PPC_KEY_START_NEXT, 4'h0);
		chk({mem_cmd, mem_cmd_step}, {`PPC_CMD_INSERT_NET, 8'h06});
		@(posedge clock) screen_empty <= 1'b1;
		key(`PPC_KEY_START_NEXT, 4'h0);
		chk({mem_cmd, mem_cmd_step}, {`PPC_CMD_INSERT_NET, 8'h01});
		@(posedge clock) cursor_relay <= 1'b1;
		key(`PPC_KEY_DELETE, 4'h0);
		chk(mem_cmd, `PPC_CMD_NONE);
		@(posedge clock) cursor_col_bottom <= 1'b1;
		key(`PPC_KEY_DELETE, 4'h0);
		chk({mem_cmd, display_update}, {`PPC_CMD_DELETE_EL, 1'b1});
		@(posedge clock) {cursor_col_bottom, cursor_top_right_single} <= 2'b01;
		key(`PPC_KEY_DELETE, 4'h0);
		chk(mem_cmd, `PPC_CMD_DELETE_EL);
		@(posedge clock) {cursor_relay, cursor_fn_top} <= 2'b01;
		key(`PPC_KEY_DELETE, 4'h0);
		chk({mem_cmd, display_update}, {`PPC_CMD_DELETE_FN, 1'b1});
		key(`PPC_KEY_SHIFT, 4'h0);
		key(`PPC_KEY_DELETE, 4'h0);
		chk({mem_cmd, display_update}, {`PPC_CMD_DELETE_NET, 1'b1});
		key(`PPC_KEY_ENTER, 4'h0);
		chk({key_refused, mem_cmd}, {1'b1, `PPC_CMD_NONE});
		@(posedge clock) assembly_complete <= 1'b1;
		key(`PPC_KEY_ENTER, 4'h0);
		chk({key_refused, mem_cmd}, {1'b0, `PPC_CMD_ENTER_EL});
		$display("edit test done");
		@(posedge clock) {cursor_is_ref, cursor_ref} <= {1'b1, 8'h21};
		key(`PPC_KEY_DISABLE, 4'h0);
		settle(2);
		chk({ref_override, ref_forced_state}, 2'b11);
		@(posedge clock) ref_state_in <= 1'b0;
		settle(2);
		chk(ref_forced_state, 1'b1);
		key(`PPC_KEY_FORCE, 4'h0);
		settle(2);
		chk(ref_forced_state, 1'b0);
		key(`PPC_KEY_FORCE, 4'h0);
		settle(2);
		chk(ref_forced_state, 1'b1);
		key(`PPC_KEY_DISABLE, 4'h0);
		settle(2);
		chk(ref_override, 1'b0);
		$display("disable test done");
		opt(`PPC_OPT_CLEAR);
		chk(key_refused, 1'b1);
		opt(`PPC_OPT_LOAD);
		chk(key_refused, 1'b1);
		opt(`PPC_OPT_STOP);
		chk(confirm_prompt, 1'b1);
		key(`PPC_KEY_DIGIT, `PPC_OPT_LOAD);
		chk({confirm_prompt, sweep_run}, 2'b01);
		opt(`PPC_OPT_STOP);
		key(`PPC_KEY_DIGIT, `PPC_OPT_CONFIRM);
		chk(sweep_run, 1'b0);
		settle(2);
		chk(outputs_enable, 1'b0);
		opt(`PPC_OPT_CLEAR);
		chk(confirm_prompt, 1'b1);
		key(`PPC_KEY_DIGIT, `PPC_OPT_CONFIRM);
		chk(mem_cmd, `PPC_CMD_CLEAR_ALL);
		opt(`PPC_OPT_START);
		settle(2);
		chk({sweep_run, outputs_enable}, 2'b11);
		opt(`PPC_OPT_EXIT);
		chk(menu_active, 1'b0);
		$display("supervisory test done");
		conclude;
	end
endmodule
`default_nettype wire

//--- ppc_partner.sv
// Controller program memory and tape recorder model on the far side.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.vh"
module ppc_partner (
	input  wire logic       clock,
	input  wire logic [7:0] mem_addr,
	input  wire logic [7:0] mem_wdata,
	input  wire logic       mem_we,
	input  wire logic [3:0] mem_cmd,
	output var  logic [7:0] mem_rdata,
	output wire logic       tape_rx
);
	logic [7:0] mem [256];
	// The recorder never plays back here, so its line rests at the idle mark level.
	assign tape_rx = 1'b1;
	initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
	always @(posedge clock) begin
		mem_rdata <= mem[mem_addr];
		if (mem_we) mem[mem_addr] <= mem_wdata;
		if (mem_cmd == `PPC_CMD_CLEAR_ALL) begin
			for (int i = 0; i < 256; i++) mem[i] <= 8'h00;
		end
	end
endmodule
`default_nettype wire

//--- ppc_regs.vh
// Constants for the programming panel command logic.
`ifndef PPC_REGS_VH
`define PPC_REGS_VH
// ----------------------------------------
// Key codes
// ----------------------------------------
`define PPC_KEY_DIGIT      4'h0
`define PPC_KEY_START_NEXT 4'h1
`define PPC_KEY_SUPERVISOR 4'h2
`define PPC_KEY_DELETE     4'h3
`define PPC_KEY_DISABLE    4'h4
`define PPC_KEY_FORCE      4'h5
`define PPC_KEY_SHIFT      4'h6
`define PPC_KEY_ENTER      4'h7
// ----------------------------------------
// Supervisory option digits
// ----------------------------------------
`define PPC_OPT_EXIT    4'h0
`define PPC_OPT_STOP    4'h1
`define PPC_OPT_START   4'h2
`define PPC_OPT_CLEAR   4'h3
`define PPC_OPT_LOAD    4'h4
`define PPC_OPT_DUMP    4'h5
`define PPC_OPT_VERIFY  4'h6
`define PPC_OPT_CONFIRM 4'h7
// ----------------------------------------
// Memory commands
// ----------------------------------------
`define PPC_CMD_NONE       4'h0
`define PPC_CMD_INSERT_NET 4'h1
`define PPC_CMD_DELETE_EL  4'h2
`define PPC_CMD_DELETE_FN  4'h3
`define PPC_CMD_DELETE_NET 4'h4
`define PPC_CMD_CLEAR_ALL  4'h5
`define PPC_CMD_ENTER_EL   4'h6
// ----------------------------------------
// Register map
// ----------------------------------------
`define PPC_ADDR_CTRL      4'h0
`define PPC_ADDR_STATUS    4'h1
`define PPC_ADDR_WATCH_SEL 4'h2
`define PPC_ADDR_WATCH_VAL 4'h3
`define PPC_ADDR_DUMP_LEN  4'h4
`define PPC_ADDR_ERRORS    4'h5
// ----------------------------------------
// Timing
// ----------------------------------------
`define PPC_CLOCK_HZ  200000000
`define PPC_TAPE_BAUD 600
`define PPC_BIT_CYCLES (`PPC_CLOCK_HZ / `PPC_TAPE_BAUD)
`define PPC_REG_MAX   10'd999
`endif

//--- ppc_tape_port.v
// Serial tape port: 8N1 transmit and receive at the tape baud rate.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.vh"
module ppc_tape_port #(
	parameter BIT_CYCLES = `PPC_BIT_CYCLES
) (
	input  wire       clock,
	input  wire       rst,
	input  wire       tx_go,
	input  wire [7:0] tx_byte,
	output reg        tx_busy,
	output reg        tx_line,
	input  wire       rx_line,
	output reg        rx_valid,
	output reg  [7:0] rx_byte
);
	reg  [31:0] tx_count;
	reg  [3:0]  tx_bits;
	reg  [9:0]  tx_shift;
	reg  [31:0] rx_count;
	reg  [3:0]  rx_bits;
	reg  [8:0]  rx_shift;
	reg         rx_busy;

	// ----------------------------------------
	// Transmit
	// ----------------------------------------
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_busy  <= 1'b0;
			tx_line  <= 1'b1;
			tx_count <= 32'h0;
			tx_bits  <= 4'h0;
			tx_shift <= 10'h3FF;
		end else if (!tx_busy) begin
			if (tx_go) begin
				tx_busy  <= 1'b1;
				tx_shift <= {1'b1, tx_byte, 1'b0};
				tx_bits  <= 4'hA;
				tx_count <= 32'h0;
			end
		end else if (tx_count == 32'h0) begin
			if (tx_bits == 4'h0) begin
				tx_busy <= 1'b0;
			end else begin
				tx_line  <= tx_shift[0];
				tx_shift <= {1'b1, tx_shift[9:1]};
				tx_bits  <= tx_bits - 4'h1;
				tx_count <= BIT_CYCLES - 1;
			end
		end else begin
			tx_count <= tx_count - 32'h1;
		end
	end

	// ----------------------------------------
	// Receive
	// ----------------------------------------
	// Sampling at mid-bit tolerates the slow drift of a tape recorder.
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_busy  <= 1'b0;
			rx_count <= 32'h0;
			rx_bits  <= 4'h0;
			rx_shift <= 9'h0;
			rx_valid <= 1'b0;
			rx_byte  <= 8'h00;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_busy) begin
				if (!rx_line) begin
					rx_busy  <= 1'b1;
					rx_count <= BIT_CYCLES / 2;
					rx_bits  <= 4'h9;
				end
			end else if (rx_count == 32'h0) begin
				rx_shift <= {rx_line, rx_shift[8:1]};
				rx_count <= BIT_CYCLES - 1;
				if (rx_bits == 4'h0) begin
					rx_busy  <= 1'b0;
					rx_valid <= rx_line;
					rx_byte  <= rx_shift[8:1];
				end else begin
					rx_bits <= rx_bits - 4'h1;
				end
			end else begin
				rx_count <= rx_count - 32'h1;
			end
		end
	end
endmodule
`default_nettype wire
